// ===== can_test_mode_control.sv
// What this block does
// - Bits 10 to 8 of the master control register hold the test-mode select.
// - After reset the test-mode select reads zero, giving normal mode.
// - Codes 1 to 5 select listen-only, external self-test, internal self-test, write-error-counter and error-passive; 6 and 7 can be written and give normal mode.
// - The test-mode select may only be changed while in configuration mode.
// - In listen-only mode both error counters are cleared and held.
// - In listen-only mode the transmit output stays recessive.
// - In listen-only mode a bus message error sets interrupt flag bit 13.
// - In both self-test modes the block acknowledges its own frames.
// - In external self-test the transmit pin is driven and the receive pin sampled.
// - In internal self-test the transmit stream loops back to the receive path.
// - In internal self-test the transmit pin is recessive and the receive pin ignored.
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
module can_test_mode_control
    import can_test_pkg::*;
(
    input wire logic clock, // 100 MHz clock.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic [3:0] avs_address, // Byte address.
    input wire logic avs_read, // Read request.
    input wire logic avs_write, // Write request.
    input wire logic [31:0] avs_writedata, // Write data.
    input wire logic [3:0] avs_byteenable, // Byte lanes.
    output logic [31:0] avs_readdata, // Read data.
    output logic avs_waitrequest, // Stall.
    input wire logic core_tx_bit, // Protocol core transmit bit.
    input wire logic core_ack_slot, // Core is in the acknowledge slot.
    input wire logic core_own_frame, // Core is sending its own frame.
    input wire logic core_tx_err, // Core transmit error event.
    input wire logic core_rx_err, // Core receive error event.
    input wire logic core_msg_err, // Core detected a message error.
    input wire logic can_rx_pin, // Receive pin, asynchronous.
    output logic can_tx_pin, // Transmit pin, 1 is recessive.
    output logic core_rx_bit, // Receive bit to the core.
    output logic self_ack, // Drive own acknowledge.
    output logic [7:0] tx_err_count, // Transmit error counter.
    output logic [7:0] rx_err_count, // Receive error counter.
    output logic [2:0] active_mode, // Mode in force.
    output logic irq // Level interrupt.
);

////////////////////////////////////////////////////////////////////////////
// Register bus.

    logic config_q;
    logic [2:0] test_sel_q;
    test_mode_t mode_q;
    logic [15:0] irq_status_q;
    logic [15:0] irq_mask_q;
    logic [31:0] rdata_q;
    logic wait_q;
    logic rx_s1_q;
    logic rx_s2_q;
    logic [7:0] tx_cnt_q;
    logic [7:0] rx_cnt_q;
    logic [15:0] irq_set_d;
    logic wr_ok;
    logic rd_ok;

    // One wait cycle per access. Read data is captured at the edge that first
    // sees the request, so it already stands while waitrequest is low.
    assign wr_ok = avs_write && !wait_q;
    assign rd_ok = avs_read && wait_q;

    // Waitrequest is low for exactly one cycle after the request is seen.
    always_ff @(posedge clock) begin
        if (srst) begin
            wait_q <= 1'b1;
        end else if ((avs_read || avs_write) && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end
    assign avs_waitrequest = wait_q;

    // Configuration bit and test-mode select.
    always_ff @(posedge clock) begin
        if (srst) begin
            config_q <= CTRL_RESET[CONFIG_BIT];
            test_sel_q <= TEST_RESET;
        end else if (!wait_q && avs_write && avs_address == CTRL_OFS) begin
            if (avs_byteenable[0]) begin
                config_q <= avs_writedata[CONFIG_BIT];
            end
            // Writes outside configuration are dropped.
            if (avs_byteenable[1] && config_q) begin
                test_sel_q <= avs_writedata[TEST_MSB:TEST_LSB];
            end
        end
    end

    // The mode in force is loaded only while configuring.
    always_ff @(posedge clock) begin
        if (srst) begin
            mode_q <= MODE_NORMAL;
        end else if (config_q) begin
            case (test_sel_q)
                3'h1: mode_q <= MODE_LISTEN;
                3'h2: mode_q <= MODE_EXT_SELF;
                3'h3: mode_q <= MODE_INT_SELF;
                3'h4: mode_q <= MODE_WR_ERRCNT;
                3'h5: mode_q <= MODE_ERR_PASSIVE;
                default: mode_q <= MODE_NORMAL; // Forbidden codes act normal.
            endcase
        end
    end
    assign active_mode = mode_q;

    // Read mux; unmapped addresses read zero.
    always_ff @(posedge clock) begin
        if (srst) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_ok) begin
            case (avs_address)
                CTRL_OFS: rdata_q <= {21'h0, test_sel_q, 7'h0, config_q};
                STATUS_OFS: rdata_q <= {13'h0, mode_q, rx_cnt_q, tx_cnt_q};
                IRQ_STATUS_OFS: rdata_q <= {16'h0, irq_status_q};
                IRQ_MASK_OFS: rdata_q <= {16'h0, irq_mask_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end
    assign avs_readdata = rdata_q;

////////////////////////////////////////////////////////////////////////////
// Pin paths.

    // Two-flop synchroniser on the receive pin.
    always_ff @(posedge clock) begin
        if (srst) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
        end else begin
            rx_s1_q <= can_rx_pin;
            rx_s2_q <= rx_s1_q;
        end
    end

    // Transmit pin: recessive in listen-only and internal loopback.
    always_ff @(posedge clock) begin
        if (srst || config_q) begin
            can_tx_pin <= 1'b1;
        end else if (mode_q == MODE_LISTEN) begin
            can_tx_pin <= 1'b1;
        end else if (mode_q == MODE_INT_SELF) begin
            can_tx_pin <= 1'b1;
        end else begin
            can_tx_pin <= core_tx_bit;
        end
    end

    // Receive path: loopback ignores the pin. The loopback skips the transmit
    // register and the pin synchroniser, so it is three cycles earlier than the bus path.
    always_ff @(posedge clock) begin
        if (srst) begin
            core_rx_bit <= 1'b1;
        end else if (mode_q == MODE_INT_SELF && !config_q) begin
            core_rx_bit <= core_tx_bit;
        end else begin
            core_rx_bit <= rx_s2_q;
        end
    end

    // Own acknowledge in both self-test modes.
    always_ff @(posedge clock) begin
        if (srst) begin
            self_ack <= 1'b0;
        end else begin
            self_ack <= !config_q && core_ack_slot && core_own_frame &&
                (mode_q == MODE_EXT_SELF || mode_q == MODE_INT_SELF);
        end
    end

////////////////////////////////////////////////////////////////////////////
// Error counters.

    // Counters saturate; listen-only clears and holds them.
    always_ff @(posedge clock) begin
        if (srst || (mode_q == MODE_LISTEN)) begin
            tx_cnt_q <= CNT_RESET;
            rx_cnt_q <= CNT_RESET;
        end else begin
            if (core_tx_err && tx_cnt_q != CNT_MAX) begin
                tx_cnt_q <= tx_cnt_q + 8'h01;
            end
            if (core_rx_err && rx_cnt_q != CNT_MAX) begin
                rx_cnt_q <= rx_cnt_q + 8'h01;
            end
        end
    end
    assign tx_err_count = tx_cnt_q;
    assign rx_err_count = rx_cnt_q;

////////////////////////////////////////////////////////////////////////////
// Interrupts.

    // Event sources into the sticky status.
    always_comb begin
        irq_set_d = 16'h0000;
        irq_set_d[IRQ_MSG_ERR_BIT] = core_msg_err && mode_q == MODE_LISTEN
            && !config_q;
        irq_set_d[IRQ_TX_ERR_BIT] = core_tx_err;
        irq_set_d[IRQ_RX_ERR_BIT] = core_rx_err;
    end

    // Write one to clear; a same-cycle event wins over the clear.
    always_ff @(posedge clock) begin
        if (srst) begin
            irq_status_q <= 16'h0000;
        end else if (wr_ok && avs_address == IRQ_STATUS_OFS) begin
            irq_status_q <= ((irq_status_q & ~avs_writedata[15:0])
                | irq_set_d) & IRQ_USED;
        end else begin
            irq_status_q <= irq_status_q | irq_set_d;
        end
    end

    // Mask register.
    always_ff @(posedge clock) begin
        if (srst) begin
            irq_mask_q <= 16'h0000;
        end else if (wr_ok && avs_address == IRQ_MASK_OFS) begin
            irq_mask_q <= avs_writedata[15:0] & IRQ_USED;
        end
    end

    // Registered level interrupt.
    always_ff @(posedge clock) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_q & irq_mask_q);
        end
    end

////////////////////////////////////////////////////////////////////////////
// Checks.

    property p_reset_mode;
        @(posedge clock) srst |=> (mode_q == MODE_NORMAL && test_sel_q == 3'h0);
    endproperty
    a_reset_mode: assert property (p_reset_mode)
        else $error("mode not normal after reset");

    property p_sel_locked;
        @(posedge clock) disable iff (srst)
            !config_q |=> $stable(test_sel_q);
    endproperty
    a_sel_locked: assert property (p_sel_locked)
        else $error("test select changed outside configuration");

    property p_mode_held;
        @(posedge clock) disable iff (srst)
            !config_q ##1 !config_q |-> $stable(mode_q);
    endproperty
    a_mode_held: assert property (p_mode_held)
        else $error("active mode changed outside configuration");

    property p_listen_cnt;
        @(posedge clock) disable iff (srst)
            mode_q == MODE_LISTEN |=> tx_cnt_q == 8'h00 && rx_cnt_q == 8'h00;
    endproperty
    a_listen_cnt: assert property (p_listen_cnt)
        else $error("error counters move in listen-only");

    property p_listen_tx;
        @(posedge clock) disable iff (srst)
            mode_q == MODE_LISTEN |=> can_tx_pin && !self_ack;
    endproperty
    a_listen_tx: assert property (p_listen_tx)
        else $error("transmit driven in listen-only");

    property p_msg_err;
        @(posedge clock) disable iff (srst)
            core_msg_err && mode_q == MODE_LISTEN && !config_q
            |=> irq_status_q[IRQ_MSG_ERR_BIT];
    endproperty
    a_msg_err: assert property (p_msg_err)
        else $error("message error flag not set");

    property p_self_ack;
        @(posedge clock) disable iff (srst)
            !config_q && core_ack_slot && core_own_frame &&
            (mode_q == MODE_EXT_SELF || mode_q == MODE_INT_SELF)
            ##1 !config_q |-> self_ack;
    endproperty
    a_self_ack: assert property (p_self_ack)
        else $error("own acknowledge missing in self-test");

    property p_ext_tx;
        @(posedge clock) disable iff (srst)
            mode_q == MODE_EXT_SELF && !config_q
            |=> can_tx_pin == $past(core_tx_bit);
    endproperty
    a_ext_tx: assert property (p_ext_tx)
        else $error("transmit pin not driven in external self-test");

    property p_loop;
        @(posedge clock) disable iff (srst)
            mode_q == MODE_INT_SELF && !config_q
            |=> core_rx_bit == $past(core_tx_bit);
    endproperty
    a_loop: assert property (p_loop)
        else $error("loopback path broken");

    property p_int_tx;
        @(posedge clock) disable iff (srst)
            mode_q == MODE_INT_SELF |=> can_tx_pin;
    endproperty
    a_int_tx: assert property (p_int_tx)
        else $error("transmit pin dominant in internal self-test");

endmodule

// ===== can_test_pkg.sv
package can_test_pkg;

    // Register byte offsets on the Avalon-MM slave.
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [3:0] IRQ_STATUS_OFS = 4'h8;
    localparam logic [3:0] IRQ_MASK_OFS = 4'hc;

    // Master control register fields.
    localparam int CONFIG_BIT = 0;
    localparam int TEST_LSB = 8;
    localparam int TEST_MSB = 10;
    localparam logic [2:0] TEST_RESET = 3'h0;

    // Interrupt status bit positions.
    localparam int IRQ_MSG_ERR_BIT = 13;
    localparam int IRQ_TX_ERR_BIT = 0;
    localparam int IRQ_RX_ERR_BIT = 1;
    localparam logic [15:0] IRQ_USED = 16'h2003;

    // Reset values.
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hff;

    // Test-mode encodings.
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h0,
        MODE_LISTEN = 3'h1,
        MODE_EXT_SELF = 3'h2,
        MODE_INT_SELF = 3'h3,
        MODE_WR_ERRCNT = 3'h4,
        MODE_ERR_PASSIVE = 3'h5
    } test_mode_t;

endpackage

// ===== can_bus_model.sv
// Bus seen through the transceiver, with one other node attached.
module can_bus_model (
    input wire logic can_tx_pin, // Device transmit pin, 1 is recessive.
    input wire logic node_dom, // Other node pulls the bus dominant.
    output logic can_rx_pin // Bus level returned to the device.
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////
    // Wired-AND: a dominant 0 from either party wins the bus.
    // A frame sent in external self-test comes back by this path.
    always_comb begin
        can_rx_pin = can_tx_pin & ~node_dom;
    end
endmodule

// ===== tb.sv
// Self-checking bench for the test-mode control block.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import can_test_pkg::*;

    logic clock = 0, srst = 1, avs_read = 0, avs_write = 0;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic avs_waitrequest, can_rx_pin, can_tx_pin, core_rx_bit, self_ack, irq;
    logic core_tx_bit = 1, core_ack_slot = 0, core_own_frame = 0;
    logic core_tx_err = 0, core_rx_err = 0, core_msg_err = 0, node_dom = 0;
    logic [7:0] tx_err_count, rx_err_count, exp_cnt;
    logic [2:0] active_mode, m;
    logic b, dm, xt, ak;
    int num_errors = 0, compares = 0, cycles = 0, n;

    can_test_mode_control i_dut (.clock(clock), .srst(srst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .core_tx_bit(core_tx_bit),
        .core_ack_slot(core_ack_slot), .core_own_frame(core_own_frame),
        .core_tx_err(core_tx_err), .core_rx_err(core_rx_err),
        .core_msg_err(core_msg_err), .can_rx_pin(can_rx_pin),
        .can_tx_pin(can_tx_pin), .core_rx_bit(core_rx_bit),
        .self_ack(self_ack), .tx_err_count(tx_err_count),
        .rx_err_count(rx_err_count), .active_mode(active_mode), .irq(irq));

    can_bus_model i_bus (.can_tx_pin(can_tx_pin), .node_dom(node_dom),
        .can_rx_pin(can_rx_pin));

    ////////////////////////////////////////////////////////////////////
    // Free-running clock of 10 ns and a cycle ceiling against hangs.
    always #5 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Holds the request until waitrequest is sampled low at a rising edge,
    // takes read data at that edge and only then releases.
    task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Pins that only listen-only and internal self-test keep recessive.
    function automatic logic exp_tx(logic [2:0] md, logic bit_in);
        return (md == MODE_LISTEN || md == MODE_INT_SELF) ? 1'b1 : bit_in;
    endfunction

    task automatic report_and_stop();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Main sequence: reset values, then every mode with random traffic.
    initial begin
        n = $urandom(32'hce2450e6);
        exp_cnt = 8'h00;
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        bus(1'b0, 4'h0, 32'h0);
        chk("test_mode_select", rd[10:8], 3'h0);
        chk("config bit", rd[0], 1'b1);
        chk("active_mode", active_mode, MODE_NORMAL);
        bus(1'b0, 4'h6, 32'h0);
        chk("unmapped", rd, 32'h0);
        bus(1'b1, IRQ_MASK_OFS, 32'h0000_2000);
        $display("test reset done");
        for (int k = 0; k < 6; k++) begin
            m = k[2:0];
            // Enter configuration first: a select written while the
            // block is out of configuration is dropped.
            bus(1'b1, 4'h0, 32'h0000_0001);
            bus(1'b1, 4'h0, {21'h0, m, 8'h01});
            bus(1'b0, 4'h0, 32'h0);
            chk("test_mode_select", rd[10:8], m);
            // Bit timing is taken as set up; leave configuration to run.
            bus(1'b1, 4'h0, {21'h0, m, 8'h00});
            bus(1'b1, 4'h0, {21'h0, m ^ 3'h1, 8'h00});
            @(negedge clock);
            chk("active_mode", active_mode, m);
            @(posedge clock);
            core_own_frame <= 1'b1;
            repeat (6) begin
                @(posedge clock);
                b = $urandom;
                dm = $urandom;
                ak = $urandom;
                core_tx_bit <= b;
                node_dom <= dm;
                core_ack_slot <= ak;
                repeat (6) @(posedge clock);
                @(negedge clock);
                xt = exp_tx(m, b);
                chk("can_tx_pin", can_tx_pin, xt);
                chk("core_rx_bit", core_rx_bit,
                    (m == MODE_INT_SELF) ? b : (xt & ~dm));
                chk("self_ack", self_ack,
                    ak && (m == MODE_EXT_SELF || m == MODE_INT_SELF));
            end
            n = 1 + $urandom % 5;
            exp_cnt = (m == MODE_LISTEN) ? 8'h00 : exp_cnt + n[7:0];
            repeat (n) begin
                @(posedge clock);
                {core_tx_err, core_rx_err, core_msg_err} <= 3'b111;
                @(posedge clock);
                {core_tx_err, core_rx_err, core_msg_err} <= 3'b000;
            end
            repeat (3) @(posedge clock);
            @(negedge clock);
            chk("irq", irq, m == MODE_LISTEN);
            chk("transmit_error_counter", tx_err_count, exp_cnt);
            chk("receive_error_counter", rx_err_count, exp_cnt);
            bus(1'b0, STATUS_OFS, 32'h0);
            chk("status", rd[18:0], {m, exp_cnt, exp_cnt});
            bus(1'b0, IRQ_STATUS_OFS, 32'h0);
            chk("message_error_flag", rd[13], m == MODE_LISTEN);
            bus(1'b1, IRQ_STATUS_OFS, 32'hffff_ffff);
            repeat (2) @(posedge clock);
            @(negedge clock);
            chk("irq cleared", irq, 1'b0);
            $display("test mode %0d done", m);
        end
        report_and_stop();
    end
endmodule
